// ===== adc_pipe_pkg.sv
// package: constants and carrier types for the two-step converter pipeline
package adc_pipe_pkg;

    // ==========================================================
    // widths and code layout
    // ==========================================================
    localparam int unsigned WORD_WIDTH   = 8;
    localparam int unsigned NIBBLE_WIDTH = 4;
    localparam int unsigned COARSE_LSB   = 4;   // coarse nibble position
    localparam int unsigned FINE_STAGES  = 2;

    // straight binary codes at the reference ends and mid scale
    localparam logic [7:0] CODE_BOTTOM = 8'h00;
    localparam logic [7:0] CODE_MID    = 8'h80;
    localparam logic [7:0] CODE_TOP    = 8'hFF;

    // ==========================================================
    // reset values and latency
    // ==========================================================
    localparam logic [7:0] WORD_RESET   = 8'h00;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    // latency in half clock periods: 2.5 cycles
    localparam int unsigned LATENCY_HALF_CYCLES = 5;
    localparam int unsigned FILL_RISING_EDGES   = 3;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        PHASE_SAMPLE  = 3'b001,
        PHASE_HOLD    = 3'b010,
        PHASE_COMPARE = 3'b100
    } comparator_phase_type;

    // reference command from the coarse stage to one fine stage
    typedef struct packed {
        logic       load;
        logic [3:0] fine_stage_reference_select;
    } reference_cmd_type;

    // ==========================================================
    // comparator decoding
    // ==========================================================
    // coarse flash: upper nibble of the full-scale level
    function automatic logic [3:0] coarse_compare(input logic [7:0] level);
        coarse_compare = level[7:4];
    endfunction : coarse_compare

    // fine flash: level measured inside the window picked by the reference
    function automatic logic [3:0] fine_compare(input logic [7:0] level,
                                                input logic [3:0] ref_sel);
        logic [7:0] residue;
        residue = level - {ref_sel, 4'h0};
        // out-of-window residue saturates instead of wrapping
        if (level < {ref_sel, 4'h0}) begin
            fine_compare = 4'h0;
        end else if (residue > 8'h0F) begin
            fine_compare = 4'hF;
        end else begin
            fine_compare = residue[3:0];
        end
    endfunction : fine_compare

endpackage : adc_pipe_pkg

// ===== fine_comparator_stage.sv
// fine comparator group: samples on falling edge, resolves on rising edges
`timescale 1ns/100ps
`default_nettype none

module fine_comparator_stage
    import adc_pipe_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            capture,
    input  wire logic [7:0]                      sampled_input_level,
    input  wire adc_pipe_pkg::reference_cmd_type ref_cmd,
    output logic [3:0]                           fine_nibble_result,
    output adc_pipe_pkg::comparator_phase_type   phase
);

    // ==========================================================
    // sampling side (falling edge)
    // ==========================================================
    logic [7:0] held_level_reg;

    // the held level stays put for the two periods this stage owns
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            held_level_reg <= WORD_RESET;
        end else if (capture) begin
            held_level_reg <= sampled_input_level;
        end
    end

    // ==========================================================
    // hold and compare side (rising edge)
    // ==========================================================
    logic [3:0]           ref_reg;
    comparator_phase_type phase_reg;
    comparator_phase_type phase_next;
    logic [3:0]           fine_reg;
    wire  [3:0]           fine_next = fine_compare(held_level_reg, ref_reg);
    // a fresh reference outranks resolving the previous sample
    wire                  resolve   = !ref_cmd.load &&
                                      (phase_reg == PHASE_COMPARE);

    // phase sequence: a reference starts compare, compare falls back to
    // sample, and a sample slot with no capture waits in hold
    always_comb begin
        phase_next = phase_reg;
        if (ref_cmd.load) begin
            phase_next = PHASE_COMPARE;
        end else begin
            unique case (phase_reg)
                PHASE_SAMPLE: begin
                    if (!capture) begin
                        phase_next = PHASE_HOLD;
                    end
                end
                PHASE_HOLD: begin
                    phase_next = PHASE_HOLD;
                end
                PHASE_COMPARE: begin
                    phase_next = PHASE_SAMPLE;
                end
                default: begin
                    phase_next = PHASE_SAMPLE;  // illegal code recovers
                end
            endcase
        end
    end

    // reference and result flops only move on their own strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_reg   <= NIBBLE_RESET;
            phase_reg <= PHASE_SAMPLE;
            fine_reg  <= NIBBLE_RESET;
        end else begin
            phase_reg <= phase_next;
            if (ref_cmd.load) begin
                ref_reg <= ref_cmd.fine_stage_reference_select;
            end
            if (resolve) begin
                fine_reg <= fine_next;
            end
        end
    end

    assign fine_nibble_result = fine_reg;
    assign phase              = phase_reg;

endmodule : fine_comparator_stage

`default_nettype wire

// ===== two_step_adc_output_pipeline.sv
// top: digital sequencing of an 8-bit two-step flash converter
`timescale 1ns/100ps
`default_nettype none

// Operation
// - output word is unsigned straight binary: 0 bottom, 255 top, 128 mid.
// - result is coarse nibble above, fine nibble below.
// - fine comparators alternate sample and compare on the clock; hold only waits out a missed capture.
// - falling edge captures input into coarse and the assigned fine stage.
// - first rising edge finalises coarse result and selects fine reference.
// - second rising edge finalises the fine result.
// - third rising edge drives the merged word onto the output bus.
// - output lags its sampling falling edge by 2.5 clock cycles.
// - the two fine stages alternate between successive samples.
// - after filling, one new word on every rising edge.
module two_step_adc_output_pipeline
    import adc_pipe_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sampled_input_level,
    output logic [7:0]      sample_bus_bits,
    output logic            word_valid
);

    // ==========================================================
    // falling-edge sampling and fine stage steering
    // ==========================================================
    // schedule per sample k: falling edge f(k) captures, rising edge
    // r(k+1) finalises coarse, r(k+2) finalises fine, r(k+3) drives the
    // bus; the half period before r(k+1) is what makes the 2.5 cycles,
    // and every stage below is one flop deep so nothing can stall
    logic [7:0] coarse_hold_reg;
    logic       stage_sel_reg;     // fine stage taking the next sample
    logic       token_reg;         // marks that a sample was captured

    // true when the one-bit stage index names the given fine stage;
    // shared by the capture steering and the reference steering
    function automatic logic stage_is(input logic sel,
                                      input logic idx);
        stage_is = (sel == idx);
    endfunction : stage_is

    // the level is a same-clock value, so it is sampled without synchroniser
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            coarse_hold_reg <= WORD_RESET;
        end else begin
            coarse_hold_reg <= sampled_input_level;
        end
    end

    // selector flips on every capture so consecutive samples alternate
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            stage_sel_reg <= 1'b0;
        end else begin
            stage_sel_reg <= ~stage_sel_reg;
        end
    end

    // first capture after reset starts the fill; only reset clears it
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            token_reg <= 1'b0;
        end else begin
            token_reg <= 1'b1;
        end
    end

    // stage a captures when the selector points at it, stage b otherwise
    wire capture_a = stage_is(stage_sel_reg, 1'b0);
    wire capture_b = stage_is(stage_sel_reg, 1'b1);

    // ==========================================================
    // rising edge one: coarse result and reference select
    // ==========================================================
    logic [3:0] coarse_reg;
    logic       ref_stage_reg;     // stage that got the reference
    logic       fill_1_reg;
    wire  [3:0] coarse_next = coarse_compare(coarse_hold_reg);
    // the stage that just captured is the one the selector left behind
    wire        just_captured = ~stage_sel_reg;
    // no reference before a real sample sits in the coarse hold
    wire        ref_load_a = token_reg && stage_is(just_captured, 1'b0);
    wire        ref_load_b = token_reg && stage_is(just_captured, 1'b1);

    reference_cmd_type ref_cmd_a;
    reference_cmd_type ref_cmd_b;

    // reference goes straight from the coarse comparators to the fine stage
    assign ref_cmd_a.load = ref_load_a;
    assign ref_cmd_a.fine_stage_reference_select = coarse_next;
    assign ref_cmd_b.load = ref_load_b;
    assign ref_cmd_b.fine_stage_reference_select = coarse_next;

    // coarse nibble is final one rising edge after its capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coarse_reg <= NIBBLE_RESET;
        end else begin
            coarse_reg <= coarse_next;
        end
    end

    // remembers which stage got this edge's reference, for the merge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_stage_reg <= 1'b0;
        end else begin
            ref_stage_reg <= just_captured;
        end
    end

    // first fill step: a sample has reached the coarse result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_1_reg <= 1'b0;
        end else begin
            fill_1_reg <= token_reg;
        end
    end

    // ==========================================================
    // fine comparator groups
    // ==========================================================
    // phase outputs stay open: the merge tracks stages by index, which
    // the alternating selector already provides
    logic [3:0] fine_a;
    logic [3:0] fine_b;

    // stage a takes the first sample after reset and every second one
    fine_comparator_stage u_fine_a (
        .clk                 (clk),
        .rst                 (rst),
        .capture             (capture_a),
        .sampled_input_level (sampled_input_level),
        .ref_cmd             (ref_cmd_a),
        .fine_nibble_result  (fine_a),
        .phase               ()
    );

    // stage b takes the samples in between
    fine_comparator_stage u_fine_b (
        .clk                 (clk),
        .rst                 (rst),
        .capture             (capture_b),
        .sampled_input_level (sampled_input_level),
        .ref_cmd             (ref_cmd_b),
        .fine_nibble_result  (fine_b),
        .phase               ()
    );

    // ==========================================================
    // rising edge two: fine resolved, coarse carried along
    // ==========================================================
    logic [3:0] coarse_delay_reg;
    logic       fine_stage_reg;    // stage whose fine result is current
    logic       fill_2_reg;

    // coarse waits one period so both halves line up for the merge; a
    // shorter path would pair this coarse with the previous fine nibble
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coarse_delay_reg <= NIBBLE_RESET;
        end else begin
            coarse_delay_reg <= coarse_reg;
        end
    end

    // the stage that got the reference last edge resolves on this one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fine_stage_reg <= 1'b0;
        end else begin
            fine_stage_reg <= ref_stage_reg;
        end
    end

    // second fill step: the first fine nibble is now final
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_2_reg <= 1'b0;
        end else begin
            fill_2_reg <= fill_1_reg;
        end
    end

    // ==========================================================
    // rising edge three: merge and drive the bus
    // ==========================================================
    wire [3:0] fine_pick  = fine_stage_reg ? fine_b : fine_a;
    // coarse is the upper nibble, so mid scale is msb alone
    wire [7:0] word_next  = {coarse_delay_reg, fine_pick};

    logic [7:0] word_reg;
    logic       valid_reg;

    // a new word every rising edge; 2.5 cycles after its falling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_reg <= WORD_RESET;
        end else begin
            word_reg <= word_next;
        end
    end

    // words before the third edge carry reset filler, so they are flagged
    // rather than suppressed: the bus itself never stalls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= fill_2_reg;
        end
    end

    // both outputs come straight from their flops
    assign sample_bus_bits = word_reg;
    assign word_valid      = valid_reg;

endmodule : two_step_adc_output_pipeline

`default_nettype wire

// ===== adc_pipe_properties.sv
// checker: timing and code relations of the converter output pipeline
`timescale 1ns/100ps
`default_nettype none

module adc_pipe_properties
    import adc_pipe_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] sampled_input_level,
    input wire logic [7:0] sample_bus_bits,
    input wire logic       word_valid
);
    // ==========================================================
    // helper logic
    // ==========================================================
    logic [7:0] lvl_fall;  // level taken at the last falling edge
    logic [7:0] bus_fall;  // bus seen at the last falling edge
    logic [2:0] edge_cnt;  // rising edges since reset
    logic [3:0] hi_fall;
    logic [3:0] lo_fall;
    assign hi_fall = lvl_fall[7:4];
    assign lo_fall = lvl_fall[3:0];

    // mirror the falling-edge sampling, so no bench timing is assumed
    always_ff @(negedge clk) begin
        lvl_fall <= sampled_input_level;
        bus_fall <= sample_bus_bits;
    end
    // saturates, so it never wraps back into the fill window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) edge_cnt <= 3'h0;
        else if (edge_cnt != 3'h7) edge_cnt <= edge_cnt + 3'h1;
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_word_latency: assert property (word_valid |->
        sample_bus_bits == $past(lvl_fall, 3)) else $error("late word");
    a_upper_coarse: assert property (word_valid |->
        sample_bus_bits[7:4] == $past(hi_fall, 3)) else $error("coarse");
    a_lower_fine: assert property (word_valid |->
        sample_bus_bits[3:0] == $past(lo_fall, 3)) else $error("fine");
    a_fill_edges: assert property (
        word_valid == (edge_cnt >= 3'h3)) else $error("fill edge");
    a_valid_holds: assert property (
        $rose(word_valid) |-> word_valid [*8]) else $error("valid drop");
    a_word_per_clock: assert property (word_valid &&
        $past(word_valid) && ($past(lvl_fall, 3) != $past(lvl_fall, 4))
        |-> $changed(sample_bus_bits)) else $error("word stuck");
    a_rise_only: assert property (
        sample_bus_bits == bus_fall) else $error("bus moved low");
    a_reset_clear: assert property ($past(rst) |->
        sample_bus_bits == WORD_RESET && !word_valid) else $error("rst");
    a_mid_code: assert property (word_valid &&
        $past(lvl_fall, 3) == CODE_MID |-> sample_bus_bits[7] &&
        sample_bus_bits[6:0] == 7'h00) else $error("mid code");

    c_fill: cover property ($rose(word_valid));
    c_top: cover property (word_valid && sample_bus_bits == CODE_TOP);
    c_bottom: cover property (word_valid && sample_bus_bits == CODE_BOTTOM);
endmodule : adc_pipe_properties

bind two_step_adc_output_pipeline adc_pipe_properties i_props (
    .clk(clk), .rst(rst), .sampled_input_level(sampled_input_level),
    .sample_bus_bits(sample_bus_bits), .word_valid(word_valid));
`default_nettype wire

// ===== sample_capture.sv
// partner: downstream logic capturing words from the sample bus
`timescale 1ns/100ps
`default_nettype none

module sample_capture (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] sample_bus_bits,
    input wire logic       word_valid
);
    logic [7:0] got_words[$];  // words in arrival order, one per clock

    // ==========================================================
    // capture
    // ==========================================================
    // read mid-period, where the bus is settled; unfilled words dropped
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            got_words.delete();
        end else if (word_valid) begin
            got_words.push_back(sample_bus_bits);
        end
    end
endmodule : sample_capture
`default_nettype wire

// ===== tb_top.sv
// testbench: streams levels through the converter and checks the words
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import adc_pipe_pkg::*;
    logic       clk;
    logic       rst;
    logic [7:0] level;
    logic [7:0] bus;
    logic       valid;
    int         num_errors;
    int         n_tests;
    logic [7:0] q[$];
    int         fill;

    two_step_adc_output_pipeline i_dut (.clk(clk), .rst(rst),
        .sampled_input_level(level), .sample_bus_bits(bus),
        .word_valid(valid));
    sample_capture i_cap (.clk(clk), .rst(rst), .sample_bus_bits(bus),
        .word_valid(valid));

    // ==========================================================
    // clock and shared tasks
    // ==========================================================
    // 50 MHz
    always #10 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // reset, one level per clock, flush, compare; fill stays 0 on a hang
    task automatic run_stream();
        int n;
        n = q.size();
        fill = 0;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        level <= q[0];
        for (int i = 1; i < n + 4; i++) begin
            @(posedge clk);
            if (i < n) level <= q[i];
            @(negedge clk);
            if (fill == 0 && valid === 1'b1) fill = i;
        end
        check(8'(i_cap.got_words.size() >= n), 8'h01);
        for (int i = 0; i < n && i < i_cap.got_words.size(); i++)
            check(i_cap.got_words[i], q[i]);
    endtask : run_stream

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_fill();
        q = '{8'h5A, 8'hA5, 8'h3C};
        run_stream();
        check(8'(fill), 8'(FILL_RISING_EDGES));
        $display("fill test done");
    endtask : t_fill

    task automatic t_codes();
        q = '{CODE_BOTTOM, CODE_MID, CODE_TOP, 8'h7F, 8'h01, 8'hFE};
        run_stream();
        $display("code test done");
    endtask : t_codes

    // distinct nibbles per sample expose a fine stage swapped or reused
    task automatic t_alternate();
        q = {};
        for (int i = 0; i < 16; i++) q.push_back({4'(i), 4'(15 - i)});
        run_stream();
        $display("alternate test done");
    endtask : t_alternate

    // reset lands while words stream, then the pipeline refills
    task automatic t_midreset();
        check(8'(valid), 8'h01);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        check(bus, WORD_RESET);
        check(8'(valid), 8'h00);
        q = '{8'hC3, 8'h3C};
        run_stream();
        check(8'(fill), 8'(FILL_RISING_EDGES));
        $display("mid reset test done");
    endtask : t_midreset

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        level = 8'h00;
        num_errors = 0;
        n_tests = 0;
        t_fill();
        t_codes();
        t_alternate();
        t_midreset();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
